// *** inc/spc_defs.svh ***
// offsets, field positions, reset values and widths of the system pll control block
// assumes an apb slave port with 12-bit byte addresses and 32-bit data
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

`define SPC_ADDR_W     12
`define SPC_CTRL_OFF   12'h000
`define SPC_STAT_OFF   12'h004
`define SPC_FREQ_OFF   12'h008

`define SPC_ODIV_W     3
`define SPC_ODIV_LSB   24
`define SPC_MULT_W     7
`define SPC_MULT_LSB   16
`define SPC_ISEL_BIT   7
`define SPC_CTRL_MASK  32'h077F0080

`define SPC_ODIV_RST   3'h0
`define SPC_MULT_RST   7'h01
`define SPC_ISEL_RST   1'b0

`define SPC_FACT_W     5
`define SPC_SHIFT_W    4
`define SPC_ODIV_TOP   3'h7
`define SPC_SHIFT_TOP  4'h8

`define SPC_STAT_REJ   0
`define SPC_STAT_USED  1
`define SPC_STAT_INUSE 2
`define SPC_STAT_UNLK  3
`define SPC_STAT_RSVD  4
`define SPC_STAT_RDY   5

`define SPC_FREQ_W     32
`define SPC_IN_FREQ_W  24

`endif

// *** inc/spc_pkg.sv ***
// types of the system pll control block
// assumes spc_defs.svh is on the include path
package spc_pkg;
  `include "spc_defs.svh"

  typedef enum logic {
    SPC_LOAD = 1'b0,
    SPC_RUN  = 1'b1
  } spc_mode_e;

  typedef struct packed {
    logic [`SPC_ODIV_W-1:0] pll_out_divider;
    logic [`SPC_MULT_W-1:0] pll_multiplier;
    logic                   pll_input_select;
  } spc_ctrl_s;

  typedef struct packed {
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [`SPC_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata;
    logic [3:0]             pstrb;
  } spc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } spc_apb_rsp_s;

  typedef struct packed {
    spc_mode_e   mode;
    spc_ctrl_s   ctrl;
    logic        rej;
    logic        used;
    logic [31:0] prdata;
    logic        pslverr;
  } spc_main_s;

  typedef struct packed {
    logic [`SPC_FREQ_W-1:0] freq;
    logic                   rsvd;
  } spc_freq_s;
endpackage

// *** src/spc_ratio_decode.sv ***
// decodes multiplier and divider codes into factor and shift
// assumes codes come straight from the control register
`timescale 1ns/1ps
`default_nettype none
`include "spc_defs.svh"
module spc_ratio_decode
  import spc_pkg::*;
(
  // codes
  input  wire logic [`SPC_ODIV_W-1:0]  odiv_code,
  input  wire logic [`SPC_MULT_W-1:0]  mult_code,
  // decoded
  output logic      [`SPC_FACT_W-1:0]  mult_factor,
  output logic      [`SPC_SHIFT_W-1:0] div_shift,
  output logic                         mult_reserved
);
  always_comb begin
    mult_reserved = 1'b0;
    case (mult_code)
      7'h00: mult_factor = 5'h02;
      7'h01: mult_factor = 5'h03;
      7'h02: mult_factor = 5'h04;
      7'h03: mult_factor = 5'h06;
      7'h04: mult_factor = 5'h08;
      7'h05: mult_factor = 5'h0C;
      7'h06: mult_factor = 5'h18;
      default: begin
        mult_factor   = 5'h00;
        mult_reserved = 1'b1;
      end
    endcase
    if (odiv_code == `SPC_ODIV_TOP) begin
      div_shift = `SPC_SHIFT_TOP;
    end else begin
      div_shift = {1'b0, odiv_code};
    end
  end
endmodule
`default_nettype wire

// *** src/spc_freq_calc.sv ***
// registered estimate of the pll output frequency in khz
// assumes oscillator frequencies are given as static inputs in khz
`timescale 1ns/1ps
`default_nettype none
`include "spc_defs.svh"
module spc_freq_calc
  import spc_pkg::*;
(
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  // inputs
  input  wire logic                     in_sel_frc,
  input  wire logic [`SPC_IN_FREQ_W-1:0] frc_khz,
  input  wire logic [`SPC_IN_FREQ_W-1:0] primary_osc_khz,
  input  wire logic [`SPC_FACT_W-1:0]   mult_factor,
  input  wire logic [`SPC_SHIFT_W-1:0]  div_shift,
  input  wire logic                     mult_reserved,
  // result
  output logic      [`SPC_FREQ_W-1:0]   freq_khz,
  output logic                          freq_rsvd
);
  spc_freq_s q;
  spc_freq_s d;
  logic [`SPC_IN_FREQ_W-1:0]            in_khz;
  logic [`SPC_IN_FREQ_W+`SPC_FACT_W-1:0] prod;

  always_comb begin
    in_khz = in_sel_frc ? frc_khz : primary_osc_khz;
    prod   = in_khz * mult_factor;
    d      = q;
    d.freq = `SPC_FREQ_W'(prod >> div_shift);
    d.rsvd = mult_reserved;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign freq_khz  = q.freq;
  assign freq_rsvd = q.rsvd;
endmodule
`default_nettype wire

// *** src/spc_pll_ctrl.sv ***
// system pll control register with apb slave and write protection gate
// assumes a write-protection unit drives unlock_granted, a config store
// drives pll_source_config_bit, and the clock switch reports pll_in_use
`timescale 1ns/1ps
`default_nettype none
`include "spc_defs.svh"
module spc_pll_ctrl
  import spc_pkg::*;
(
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rstn,
  // apb slave
  input  wire spc_apb_req_s              apb_req,
  output spc_apb_rsp_s                   apb_rsp,
  // system inputs
  input  wire logic                      unlock_granted,
  input  wire logic                      pll_source_config_bit,
  input  wire logic                      pll_in_use,
  input  wire logic [`SPC_IN_FREQ_W-1:0] frc_khz,
  input  wire logic [`SPC_IN_FREQ_W-1:0] primary_osc_khz,
  // pll controls
  output logic      [`SPC_ODIV_W-1:0]    pll_out_divider,
  output logic      [`SPC_MULT_W-1:0]    pll_multiplier,
  output logic                           pll_input_select,
  output logic      [`SPC_FACT_W-1:0]    pll_mult_factor,
  output logic      [`SPC_SHIFT_W-1:0]   pll_div_shift,
  // derived status
  output logic      [`SPC_FREQ_W-1:0]    pll_out_freq_khz,
  output logic                           pll_mult_reserved
);
  spc_main_s                q;
  spc_main_s                d;
  logic                     wr_go;
  logic                     rd_sel;
  logic                     hit_ctrl;
  logic                     hit_stat;
  logic                     hit_freq;
  logic                     hit_any;
  logic                     aligned;
  logic                     set_rej;
  logic                     set_used;
  logic                     clr_rej;
  logic                     clr_used;
  logic [31:0]              ctrl_word;
  logic [31:0]              stat_word;
  logic [31:0]              rd_word;
  logic [31:0]              wmask;
  logic [31:0]              new_ctrl;
  logic [`SPC_FACT_W-1:0]   fact_w;
  logic [`SPC_SHIFT_W-1:0]  shift_w;
  logic                     rsvd_w;
  logic [`SPC_FREQ_W-1:0]   freq_w;
  logic                     freq_rsvd_w;

  // code decode
  spc_ratio_decode u_dec (
    .odiv_code     (q.ctrl.pll_out_divider),
    .mult_code     (q.ctrl.pll_multiplier),
    .mult_factor   (fact_w),
    .div_shift     (shift_w),
    .mult_reserved (rsvd_w)
  );

  // frequency estimate
  spc_freq_calc u_freq (
    .ref_clk       (ref_clk),
    .rstn          (rstn),
    .in_sel_frc    (q.ctrl.pll_input_select),
    .frc_khz       (frc_khz),
    .primary_osc_khz      (primary_osc_khz),
    .mult_factor   (fact_w),
    .div_shift     (shift_w),
    .mult_reserved (rsvd_w),
    .freq_khz      (freq_w),
    .freq_rsvd     (freq_rsvd_w)
  );

  // address decode
  always_comb begin
    aligned  = (apb_req.paddr[1:0] == 2'b00);
    hit_ctrl = aligned && (apb_req.paddr == `SPC_CTRL_OFF);
    hit_stat = aligned && (apb_req.paddr == `SPC_STAT_OFF);
    hit_freq = aligned && (apb_req.paddr == `SPC_FREQ_OFF);
    hit_any  = hit_ctrl || hit_stat || hit_freq;
  end

  // byte lane mask
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign wmask[i*8 +: 8] = {8{apb_req.pstrb[i]}};
  end

  // register images
  always_comb begin
    ctrl_word = '0;
    ctrl_word[`SPC_ODIV_LSB +: `SPC_ODIV_W] = q.ctrl.pll_out_divider;
    ctrl_word[`SPC_MULT_LSB +: `SPC_MULT_W] = q.ctrl.pll_multiplier;
    ctrl_word[`SPC_ISEL_BIT] = q.ctrl.pll_input_select;
    stat_word = '0;
    stat_word[`SPC_STAT_REJ]   = q.rej;
    stat_word[`SPC_STAT_USED]  = q.used;
    stat_word[`SPC_STAT_INUSE] = pll_in_use;
    stat_word[`SPC_STAT_UNLK]  = unlock_granted;
    stat_word[`SPC_STAT_RSVD]  = freq_rsvd_w;
    stat_word[`SPC_STAT_RDY]   = (q.mode == SPC_RUN);
  end

  // read mux
  always_comb begin
    if (hit_ctrl) begin
      rd_word = ctrl_word;
    end else if (hit_stat) begin
      rd_word = stat_word;
    end else if (hit_freq) begin
      rd_word = freq_w;
    end else begin
      rd_word = '0;
    end
  end

  // write events
  always_comb begin
    wr_go    = apb_req.psel && apb_req.penable && apb_req.pwrite && (q.mode == SPC_RUN);
    rd_sel   = apb_req.psel && !apb_req.pwrite;
    set_rej  = wr_go && hit_ctrl && !unlock_granted;
    set_used = wr_go && hit_ctrl && unlock_granted && pll_in_use;
    clr_rej  = wr_go && hit_stat && apb_req.pstrb[0] && apb_req.pwdata[`SPC_STAT_REJ];
    clr_used = wr_go && hit_stat && apb_req.pstrb[0] && apb_req.pwdata[`SPC_STAT_USED];
    new_ctrl = (ctrl_word & ~wmask) | (apb_req.pwdata & wmask);
    new_ctrl = new_ctrl & `SPC_CTRL_MASK;
  end

  // next state
  always_comb begin
    d = q;
    case (q.mode)
      SPC_LOAD: begin
        d.ctrl.pll_input_select = pll_source_config_bit;
        d.mode = SPC_RUN;
      end
      SPC_RUN: begin
        if (wr_go && hit_ctrl && unlock_granted) begin
          d.ctrl.pll_out_divider  = new_ctrl[`SPC_ODIV_LSB +: `SPC_ODIV_W];
          d.ctrl.pll_multiplier   = new_ctrl[`SPC_MULT_LSB +: `SPC_MULT_W];
          d.ctrl.pll_input_select = new_ctrl[`SPC_ISEL_BIT];
        end
      end
      default: begin
        d.mode = SPC_LOAD;
      end
    endcase
    // sticky flags, set wins over clear
    d.rej  = (q.rej && !clr_rej) || set_rej;
    d.used = (q.used && !clr_used) || set_used;
    // read data and error taken ahead of the completing edge
    if (apb_req.psel) begin
      d.prdata  = rd_sel ? rd_word : '0;
      d.pslverr = !hit_any;
    end else begin
      d.prdata  = '0;
      d.pslverr = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q.mode                  <= SPC_LOAD;
      q.ctrl.pll_out_divider  <= `SPC_ODIV_RST;
      q.ctrl.pll_multiplier   <= `SPC_MULT_RST;
      q.ctrl.pll_input_select <= `SPC_ISEL_RST;
      q.rej                   <= 1'b0;
      q.used                  <= 1'b0;
      q.prdata                <= '0;
      q.pslverr               <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // apb answer, stalled until the config bit is loaded
  always_comb begin
    apb_rsp.prdata  = q.prdata;
    apb_rsp.pready  = (q.mode == SPC_RUN);
    apb_rsp.pslverr = q.pslverr && apb_req.psel && apb_req.penable;
  end

  // pll control outputs
  assign pll_out_divider   = q.ctrl.pll_out_divider;
  assign pll_multiplier    = q.ctrl.pll_multiplier;
  assign pll_input_select  = q.ctrl.pll_input_select;
  assign pll_mult_factor   = fact_w;
  assign pll_div_shift     = shift_w;
  assign pll_out_freq_khz  = freq_w;
  assign pll_mult_reserved = freq_rsvd_w;
endmodule
`default_nettype wire

// *** bench/spc_pll_chk.sv ***
// assertions on the system pll control ports
// assumes it is bound onto spc_pll_ctrl
`timescale 1ns/1ps
`default_nettype none
module spc_pll_chk
  import spc_pkg::*;
(
  // clock and reset
  input wire logic         ref_clk,
  input wire logic         rstn,
  // bus and system inputs
  input wire spc_apb_req_s apb_req,
  input wire spc_apb_rsp_s apb_rsp,
  input wire logic         unlock_granted,
  input wire logic         pll_source_config_bit,
  // pll controls
  input wire logic [2:0]   pll_out_divider,
  input wire logic [6:0]   pll_multiplier,
  input wire logic         pll_input_select,
  input wire logic [4:0]   pll_mult_factor,
  input wire logic [3:0]   pll_div_shift
);
  localparam logic [4:0] FT [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h18, 5'h00};
  logic       xf;
  logic       cw;
  logic [4:0] fac;
  assign xf  = apb_req.psel & apb_req.penable & apb_rsp.pready & (apb_req.paddr == 12'h000);
  assign cw  = xf & apb_req.pwrite;
  assign fac = (pll_multiplier > 7'h06) ? 5'h00 : FT[pll_multiplier[2:0]];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  div_write_a: assert property (cw && unlock_granted && apb_req.pstrb[3]
    |=> pll_out_divider == $past(apb_req.pwdata[26:24])) else $error("divider write lost");
  mult_write_a: assert property (cw && unlock_granted && apb_req.pstrb[2]
    |=> pll_multiplier == $past(apb_req.pwdata[22:16])) else $error("multiplier write lost");
  isel_write_a: assert property (cw && unlock_granted && apb_req.pstrb[0]
    |=> pll_input_select == $past(apb_req.pwdata[7])) else $error("input select write lost");
  locked_write_a: assert property (cw && !unlock_granted
    |=> $stable({pll_out_divider, pll_multiplier, pll_input_select})) else $error("locked write landed");
  ctrl_read_a: assert property (xf && !apb_req.pwrite |-> apb_rsp.prdata ==
    {5'h00, pll_out_divider, 1'b0, pll_multiplier, 8'h00, pll_input_select, 7'h00}) else $error("ctrl read wrong");
  div_decode_a: assert property (pll_div_shift ==
    ((pll_out_divider == 3'h7) ? 4'h8 : {1'b0, pll_out_divider})) else $error("divider decode wrong");
  mult_decode_a: assert property (pll_mult_factor == fac) else $error("multiplier decode wrong");
  isel_reset_a: assert property ($rose(rstn)
    |=> pll_input_select == $past(pll_source_config_bit)) else $error("input select reset wrong");
endmodule
bind spc_pll_ctrl spc_pll_chk chk (.ref_clk(ref_clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .unlock_granted(unlock_granted), .pll_source_config_bit(pll_source_config_bit),
  .pll_out_divider(pll_out_divider), .pll_multiplier(pll_multiplier), .pll_input_select(pll_input_select),
  .pll_mult_factor(pll_mult_factor), .pll_div_shift(pll_div_shift));
`default_nettype wire

// *** bench/spc_pll_ctrl_bench.sv ***
// self-checking bench of the system pll control block
// assumes the checker file is compiled before it
`timescale 1ns/1ps
`default_nettype none
module spc_pll_ctrl_bench
  import spc_pkg::*;
;
  localparam logic [4:0] FT [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h18, 5'h00};
  logic         ref_clk;
  logic         rstn;
  spc_apb_req_s apb_req;
  spc_apb_rsp_s apb_rsp;
  logic         ulk;
  logic         cfg;
  logic         inuse;
  logic [23:0]  internal_fast_rc_osc;
  logic [23:0]  primary_osc;
  logic [2:0]   odv;
  logic [6:0]   mul;
  logic         isl;
  logic         rsv;
  logic [31:0]  frq;
  logic [31:0]  seed;
  logic [31:0]  r;
  logic [31:0]  d;
  logic [31:0]  exp;
  logic         err;
  int           checks;
  int           bad_count;

  spc_pll_ctrl uut (.ref_clk(ref_clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .unlock_granted(ulk), .pll_source_config_bit(cfg), .pll_in_use(inuse), .frc_khz(internal_fast_rc_osc), .primary_osc_khz(primary_osc),
    .pll_out_divider(odv), .pll_multiplier(mul), .pll_input_select(isl), .pll_mult_factor(),
    .pll_div_shift(), .pll_out_freq_khz(frq), .pll_mult_reserved(rsv));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] efreq(input logic [31:0] c);
    logic [31:0] p;
    p = (c[7] ? internal_fast_rc_osc : primary_osc) * FT[c[18:16]];
    return p >> ((c[26:24] == 3'h7) ? 4'h8 : {1'b0, c[26:24]});
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    apb_req <= '{1'b1, 1'b0, w, a, wd, 4'hF};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (apb_rsp.pready === 1'b1) break;
    end
    if (n == 50) begin
      bad_count++;
      tally_and_finish();
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    seed = 32'h0000002C;
    r = rnd();
    internal_fast_rc_osc = {8'h00, r[15:0]};
    primary_osc = {8'h00, r[31:16]};
    rstn = 1'b0;
    apb_req = '0;
    ulk = 1'b1;
    cfg = 1'b1;
    inuse = 1'b0;
    checks = 0;
    bad_count = 0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, r);
    cmp("ctrl reset", r, 32'h00010080);
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      d[26:24] = i[2:0];
      d[22:16] = 7'(i % 7);
      apb(1'b1, 12'h000, d, r);
      exp = d & 32'h077F0080;
      repeat (2) @(negedge ref_clk);
      cmp("pins", {5'h00, odv, 1'b0, mul, 8'h00, isl, 7'h00}, exp);
      cmp("freq", frq, efreq(exp));
      cmp("reserved", {31'h0, rsv}, 32'h0);
      apb(1'b0, 12'h000, 32'h0, r);
      cmp("ctrl read", r, exp);
      apb(1'b0, 12'h008, 32'h0, r);
      cmp("freq reg", r, efreq(exp));
    end
    ulk <= 1'b0;
    apb(1'b1, 12'h000, rnd(), r);
    apb(1'b0, 12'h000, 32'h0, r);
    cmp("locked write", r, exp);
    apb(1'b0, 12'h004, 32'h0, r);
    cmp("reject flag", r, 32'h00000021);
    apb(1'b0, 12'h00C, 32'h0, r);
    cmp("unmapped err", {31'h0, err}, 32'h1);
    ulk <= 1'b1;
    inuse <= 1'b1;
    apb(1'b1, 12'h000, exp, r);
    apb(1'b0, 12'h004, 32'h0, r);
    cmp("status in use", r, 32'h0000002F);
    inuse <= 1'b0;
    apb(1'b1, 12'h004, 32'h3, r);
    apb(1'b0, 12'h004, 32'h0, r);
    cmp("status clear", r, 32'h00000028);
    cfg <= 1'b0;
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, r);
    cmp("ctrl reset cfg0", r, 32'h00010000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
